/* logic/arf_regs.svh */
// Purpose: register offsets, field positions and reset values of the result formatter
// Assumes: 32-bit AHB-Lite data, one register per aligned word
// Notes: definitions only
`ifndef ARF_REGS_SVH
`define ARF_REGS_SVH

`define ARF_OFS_CTRL0 8'h00
`define ARF_OFS_CTRL1 8'h04
`define ARF_OFS_CTRL2 8'h08
`define ARF_OFS_RESH 8'h0C
`define ARF_OFS_RESL 8'h10

// control zero fields
`define ARF_C0_POWER 0
`define ARF_C0_GO 1
`define ARF_C0_CHAN_LO 2
`define ARF_C0_CHAN_HI 6
// control one fields
`define ARF_C1_NREF 2
`define ARF_C1_PREF_LO 0
`define ARF_C1_PREF_HI 1
`define ARF_C1_CLK_LO 4
`define ARF_C1_CLK_HI 6
`define ARF_C1_FMT 7
// control two fields
`define ARF_C2_NCHAN_LO 0
`define ARF_C2_NCHAN_HI 3
`define ARF_C2_TRIG_LO 4
`define ARF_C2_TRIG_HI 7

`define ARF_RST_CTRL 8'h00

`endif

/* logic/arf_pkg.sv */
// Purpose: types shared by the result formatter and its users
// Assumes: nothing beyond SystemVerilog packages
// Notes: numbers live in arf_regs.svh
`default_nettype none
package arf_pkg;

	// control fields seen by the analog converter core
	typedef struct packed {
		logic [4:0] positive_channel_select;
		logic converter_power_on;
		logic [2:0] conversion_clock_select;
		logic result_format_select;
		logic negative_reference_select;
		logic [1:0] positive_reference_select;
		logic [3:0] auto_trigger_source;
		logic [3:0] negative_channel_select;
	} arf_ctrl_t;

	// one finished conversion: sign and 12 two's-complement bits
	typedef struct packed {
		logic result_sign;
		logic [11:0] value;
	} arf_conv_t;

	typedef enum logic [1:0] {
		ARF_IDLE = 2'b01,
		ARF_BUSY = 2'b10
	} arf_state_t;

endpackage
`default_nettype wire

/* logic/arf_formatter.sv */
// Purpose: converter control registers and result formatting behind an AHB-Lite slave
// Assumes: converter core runs on clk_sys; conv_done is a one-cycle pulse
// Notes: result registers carry no reset and keep their value across sys_rst
`default_nettype none
`include "arf_regs.svh"

// How it works
// (R1) left format: high register holds bits 11..4
// (R2) left format: low bits 7..4 hold bits 3..0
// (R3) left format: low bits 3..1 written zero
// (R4) left format: low bit 0 holds sign
// (R5) right format: high bits 7..4 copy sign
// (R6) right format: high bits 3..0 hold 11..8
// (R7) right format: low register holds bits 7..0
// (R8) software waits acquisition after channel change
// (R9) hold capacitor never discharged after conversion
// (R10) results read/write, unknown at power-up, kept
// (R11) both results written together at completion
// (R12) sign set when negative, two's complement value
module arf_formatter (
	input wire logic clk_sys, // 40 MHz system clock
	input wire logic sys_rst, // asynchronous reset, active high
	input wire logic hsel, // slave select
	input wire logic [7:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write when high
	input wire logic [2:0] hsize, // word transfers only
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic hreadyout, // slave ready
	output logic hresp, // always OKAY
	output logic [31:0] hrdata, // read data
	input wire logic conv_done, // conversion finished pulse
	input wire arf_pkg::arf_conv_t conv_data, // finished result
	output arf_pkg::arf_ctrl_t adc_ctrl, // control fields to the core
	output logic conv_start, // one-cycle start pulse
	output logic hold_discharge, // capacitor discharge request, held low
	output logic channel_changed // channel moved since last start
);
	import arf_pkg::*;

	typedef struct packed {
		arf_ctrl_t ctrl;
		logic go;
		arf_state_t state;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
		logic start;
		logic chg;
		logic rdy;
		logic resp;
		logic discharge;
	} arf_reg_t;

	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} arf_res_t;

	arf_reg_t st;
	arf_reg_t next_st;
	arf_res_t res;
	arf_res_t next_res;
	logic take;
	logic [7:0] wb;
	logic [7:0] c0;
	logic [7:0] c1;
	logic [7:0] c2;

	assign take = hsel & htrans[1] & hready;
	assign wb = hwdata[7:0];

	// formatted write of a finished conversion, layout chosen at completion
	function automatic arf_res_t fmt_result(input arf_conv_t cv, input logic fmt_bit);
		arf_res_t r;
		r = '{high: 8'h00, low: 8'h00};
		// format bit low selects the left layout
		if (!fmt_bit) begin
			r.high = cv.value[11:4]; // see (R1)
			r.low[7:4] = cv.value[3:0]; // see (R2)
			r.low[3:1] = 3'b000; // see (R3)
			r.low[0] = cv.result_sign; // see (R4)
		end else begin
			r.high[7:4] = {4{cv.result_sign}}; // see (R5)
			r.high[3:0] = cv.value[11:8]; // see (R6)
			r.low = cv.value[7:0]; // see (R7)
		end
		return r;
	endfunction

	// control zero write: channel and power; go is decided by the caller
	function automatic arf_ctrl_t put_ctrl0(input arf_ctrl_t c, input logic [7:0] d);
		arf_ctrl_t n;
		n = c;
		n.positive_channel_select = d[`ARF_C0_CHAN_HI:`ARF_C0_CHAN_LO];
		n.converter_power_on = d[`ARF_C0_POWER];
		return n;
	endfunction

	// control one write: format, conversion clock and references
	function automatic arf_ctrl_t put_ctrl1(input arf_ctrl_t c, input logic [7:0] d);
		arf_ctrl_t n;
		n = c;
		n.result_format_select = d[`ARF_C1_FMT];
		n.conversion_clock_select = d[`ARF_C1_CLK_HI:`ARF_C1_CLK_LO];
		n.negative_reference_select = d[`ARF_C1_NREF];
		n.positive_reference_select = d[`ARF_C1_PREF_HI:`ARF_C1_PREF_LO];
		return n;
	endfunction

	// control two write: trigger source and negative channel
	function automatic arf_ctrl_t put_ctrl2(input arf_ctrl_t c, input logic [7:0] d);
		arf_ctrl_t n;
		n = c;
		n.auto_trigger_source = d[`ARF_C2_TRIG_HI:`ARF_C2_TRIG_LO];
		n.negative_channel_select = d[`ARF_C2_NCHAN_HI:`ARF_C2_NCHAN_LO];
		return n;
	endfunction

	// register images built from the next state so reads see a write just made
	always_comb begin
		c0 = 8'h00;
		c1 = 8'h00;
		c2 = 8'h00;
		c0[`ARF_C0_CHAN_HI:`ARF_C0_CHAN_LO] = next_st.ctrl.positive_channel_select;
		c0[`ARF_C0_GO] = next_st.go;
		c0[`ARF_C0_POWER] = next_st.ctrl.converter_power_on;
		c1[`ARF_C1_FMT] = next_st.ctrl.result_format_select;
		c1[`ARF_C1_CLK_HI:`ARF_C1_CLK_LO] = next_st.ctrl.conversion_clock_select;
		c1[`ARF_C1_NREF] = next_st.ctrl.negative_reference_select;
		c1[`ARF_C1_PREF_HI:`ARF_C1_PREF_LO] = next_st.ctrl.positive_reference_select;
		c2[`ARF_C2_TRIG_HI:`ARF_C2_TRIG_LO] = next_st.ctrl.auto_trigger_source;
		c2[`ARF_C2_NCHAN_HI:`ARF_C2_NCHAN_LO] = next_st.ctrl.negative_channel_select;
	end

	always_comb begin
		next_st = st;
		next_res = res;
		next_st.start = 1'b0;
		// bus answer and capacitor control kept in flops so every output is registered
		next_st.rdy = 1'b1;
		next_st.resp = 1'b0;
		next_st.discharge = 1'b0; // see (R9)
		next_st.wr_pend = take & hwrite;
		if (take) begin
			next_st.wr_addr = haddr;
		end
		// data phase of a write
		if (st.wr_pend) begin
			case (st.wr_addr)
				`ARF_OFS_CTRL0: begin
					if (wb[`ARF_C0_CHAN_HI:`ARF_C0_CHAN_LO] != st.ctrl.positive_channel_select) begin
						next_st.chg = 1'b1; // see (R8)
					end
					next_st.ctrl = put_ctrl0(st.ctrl, wb);
					if (wb[`ARF_C0_GO] && wb[`ARF_C0_POWER] && st.state == ARF_IDLE) begin
						next_st.go = 1'b1;
						next_st.start = 1'b1;
						next_st.chg = 1'b0;
					end
				end
				`ARF_OFS_CTRL1: next_st.ctrl = put_ctrl1(st.ctrl, wb);
				`ARF_OFS_CTRL2: next_st.ctrl = put_ctrl2(st.ctrl, wb);
				`ARF_OFS_RESH: next_res.high = wb; // see (R10)
				`ARF_OFS_RESL: next_res.low = wb; // see (R10)
				default: begin
				end
			endcase
		end
		// busy tracking; a start written this cycle keeps priority
		case (st.state)
			ARF_IDLE: begin
				if (next_st.start) begin
					next_st.state = ARF_BUSY;
				end
			end
			ARF_BUSY: begin
				if (!next_st.ctrl.converter_power_on) begin
					next_st.state = ARF_IDLE;
					next_st.go = 1'b0;
				end
			end
			default: next_st.state = ARF_IDLE;
		endcase
		// completion overrides a software write to the results
		if (conv_done) begin
			next_res = fmt_result(conv_data, next_st.ctrl.result_format_select); // see (R11) (R12)
			if (st.state == ARF_BUSY) begin
				next_st.state = ARF_IDLE;
				next_st.go = 1'b0;
			end
		end
		// read data for the address phase now sampled
		next_st.rdata = 32'h0000_0000;
		if (take && !hwrite) begin
			case (haddr)
				`ARF_OFS_CTRL0: next_st.rdata = {24'h00_0000, c0};
				`ARF_OFS_CTRL1: next_st.rdata = {24'h00_0000, c1};
				`ARF_OFS_CTRL2: next_st.rdata = {24'h00_0000, c2};
				`ARF_OFS_RESH: next_st.rdata = {24'h00_0000, next_res.high};
				`ARF_OFS_RESL: next_st.rdata = {24'h00_0000, next_res.low};
				default: next_st.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '{
				ctrl: '0,
				go: 1'b0,
				state: ARF_IDLE,
				wr_pend: 1'b0,
				wr_addr: 8'h00,
				rdata: 32'h0000_0000,
				start: 1'b0,
				chg: 1'b0,
				rdy: 1'b1,
				resp: 1'b0,
				discharge: 1'b0
			};
		end else begin
			st <= next_st;
		end
	end

	// no reset: contents survive every reset, unknown only at power-up
	always_ff @(posedge clk_sys) begin
		res <= next_res; // see (R10)
	end

	assign hreadyout = st.rdy;
	assign hresp = st.resp;
	assign hrdata = st.rdata;
	assign adc_ctrl = st.ctrl;
	assign conv_start = st.start;
	assign hold_discharge = st.discharge; // see (R9)
	assign channel_changed = st.chg; // see (R8)

endmodule
`default_nettype wire

/* tb/arf_checker.sv */
// Purpose: bus and result layout checks
// Assumes: results read back after a conversion or a write
// Notes: expected results are not reset
`default_nettype none
module arf_checker import arf_pkg::*; (
	input wire logic clk_sys, // clock
	input wire logic sys_rst, // reset
	input wire logic hsel, // in
	input wire logic [7:0] haddr, // in
	input wire logic [1:0] htrans, // in
	input wire logic hwrite, // in
	input wire logic [31:0] hwdata, // in
	input wire logic hready, // in
	input wire logic hreadyout, // out
	input wire logic hresp, // out
	input wire logic [31:0] hrdata, // out
	input wire logic conv_done, // in
	input wire arf_conv_t conv_data, // in
	input wire arf_ctrl_t adc_ctrl, // out
	input wire logic conv_start, // out
	input wire logic hold_discharge // out
);
	logic v_q, w_q;
	logic [7:0] a_q, eh, el;
	logic fmt_now;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) v_q <= 1'b0;
		else v_q <= hsel & htrans[1] & hready;
	end
	// a control one write in the completion cycle already sets the layout
	assign fmt_now = (v_q && w_q && a_q == 8'h04) ? hwdata[7] : adc_ctrl.result_format_select;
	always_ff @(posedge clk_sys) begin
		a_q <= haddr;
		w_q <= hwrite;
		// format bit low is the left layout
		if (conv_done && !fmt_now) begin
			eh <= conv_data.value[11:4];
			el <= {conv_data.value[3:0], 3'b000, conv_data.result_sign};
		end else if (conv_done) begin
			eh <= {{4{conv_data.result_sign}}, conv_data.value[11:8]};
			el <= conv_data.value[7:0];
		end else if (v_q && w_q && a_q == 8'h0C) eh <= hwdata[7:0];
		else if (v_q && w_q && a_q == 8'h10) el <= hwdata[7:0];
	end
	sequence rd_s(logic [7:0] a);
		v_q && !w_q && a_q == a;
	endsequence
	hi_layout_a: assert property (rd_s(8'h0C) |-> hrdata[7:0] == eh)
		else $error("high result wrong");
	lo_layout_a: assert property (rd_s(8'h10) |-> hrdata[7:0] == el)
		else $error("low result wrong");
	rd_upper_a: assert property (v_q && !w_q |-> hrdata[31:8] == 24'h0)
		else $error("upper read bits set");
	no_discharge_a: assert property (hold_discharge == 1'b0)
		else $error("capacitor discharged");
	resp_ok_a: assert property (hreadyout && hresp == 1'b0)
		else $error("bus answer wrong");
	go_start_a: assert property (v_q && w_q && a_q == 8'h00 && hwdata[1:0] == 2'b11
		|=> conv_start ##1 !conv_start) else $error("start pulse wrong");
	fmt_set_a: assert property (v_q && w_q && a_q == 8'h04
		|=> adc_ctrl.result_format_select == $past(hwdata[7])) else $error("format bit");
	rst_ctrl_a: assert property ($fell(sys_rst) |-> adc_ctrl == '0 && !conv_start)
		else $error("control not cleared");
endmodule
bind arf_formatter arf_checker u_arf_checker(.clk_sys, .sys_rst, .hsel, .haddr, .htrans,
	.hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .conv_done, .conv_data,
	.adc_ctrl, .conv_start, .hold_discharge);
`default_nettype wire

/* tb/tb_arf_formatter.sv */
// Purpose: self-checking bench for the result formatter
// Assumes: zero wait state slave, format bit 0 is left layout
// Notes: sign is taken from bit 11 of each value
`default_nettype none
module tb_arf_formatter;
	timeunit 1ns;
	timeprecision 100ps;
	import arf_pkg::*;
	logic clk_sys = 0, sys_rst = 1, hsel = 0, hwrite = 0, conv_done = 0;
	logic hreadyout, hresp, conv_start, hold_discharge, channel_changed;
	logic [7:0] haddr = '0;
	logic [1:0] htrans = '0;
	logic [31:0] hwdata = '0, hrdata, rd;
	arf_conv_t conv_data = '0;
	arf_ctrl_t adc_ctrl;
	int error_cnt = 0, num_checks = 0;
	arf_formatter u_arf_formatter(.clk_sys, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.conv_done, .conv_data, .adc_ctrl, .conv_start, .hold_discharge, .channel_changed);
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	task results();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task reset_dut();
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
	endtask
	task t_conv(input logic fmt, input logic [11:0] v);
		logic [7:0] eh, el;
		eh = fmt ? {{4{v[11]}}, v[11:8]} : v[11:4];
		el = fmt ? v[7:0] : {v[3:0], 3'b000, v[11]};
		xfer(8'h04, 1'b1, {24'h0, fmt, 7'h00});
		xfer(8'h00, 1'b1, 32'h03);
		do @(posedge clk_sys); while (conv_start !== 1'b1);
		conv_data <= {v[11], v};
		conv_done <= 1'b1;
		@(posedge clk_sys);
		conv_done <= 1'b0;
		xfer(8'h0C, 1'b0, 32'h0);
		chk(rd, {24'h0, eh});
		xfer(8'h10, 1'b0, 32'h0);
		chk(rd, {24'h0, el});
	endtask
	task t_ctrl();
		xfer(8'h00, 1'b1, 32'h14);
		@(posedge clk_sys);
		chk({31'h0, channel_changed}, 32'h1);
		chk({27'h0, adc_ctrl.positive_channel_select}, 32'h5);
		xfer(8'h04, 1'b1, 32'h65);
		xfer(8'h08, 1'b1, 32'h96);
		@(posedge clk_sys);
		chk({24'h0, adc_ctrl.result_format_select, adc_ctrl.conversion_clock_select, 1'b0,
			adc_ctrl.negative_reference_select, adc_ctrl.positive_reference_select}, 32'h65);
		chk({24'h0, adc_ctrl.auto_trigger_source, adc_ctrl.negative_channel_select}, 32'h96);
		xfer(8'h04, 1'b0, 32'h0);
		chk(rd, 32'h65);
		xfer(8'h08, 1'b0, 32'h0);
		chk(rd, 32'h96);
		// acquisition on the new channel has had time before this start
		xfer(8'h00, 1'b1, 32'h17);
		@(posedge clk_sys);
		chk({31'h0, channel_changed}, 32'h0);
		xfer(8'h00, 1'b0, 32'h0);
		chk(rd, 32'h17);
		xfer(8'h00, 1'b1, 32'h14);
		xfer(8'h00, 1'b0, 32'h0);
		chk(rd, 32'h14);
	endtask
	task t_regs();
		xfer(8'h0C, 1'b1, 32'hA5);
		xfer(8'h10, 1'b1, 32'h3C);
		xfer(8'h0C, 1'b0, 32'h0);
		chk(rd, 32'hA5);
		reset_dut();
		xfer(8'h10, 1'b0, 32'h0);
		chk(rd, 32'h3C);
		xfer(8'h04, 1'b0, 32'h0);
		chk(rd, 32'h0);
		xfer(8'h40, 1'b0, 32'h0);
		chk(rd, 32'h0);
	endtask
	initial begin
		reset_dut();
		t_conv(1'b1, 12'h800);
		t_conv(1'b1, 12'h123);
		t_conv(1'b0, 12'hFFF);
		t_conv(1'b0, 12'h7FF);
		t_ctrl();
		t_regs();
		results();
	end
	initial begin
		#50us;
		error_cnt++;
		results();
	end
endmodule
`default_nettype wire
